/* src/cfg_load_pkg.sv */
package cfg_load_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CF2CD_MAX_NS = 600;
  localparam int CF2CD_CYC = CF2CD_MAX_NS / CLK_PERIOD_NS;
  localparam int STATUS_MIN_US = 268;
  localparam int STATUS_MIN_CYC = (STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_MAX_US = 1506;
  localparam int STATUS_MAX_CYC = (STATUS_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int UM_MIN_US = 175;
  localparam int UM_MIN_CYC = (UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UM_MAX_US = 437;
  localparam int UM_MAX_CYC = (UM_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int INIT_CYCLES = 8576;
  localparam int CFG_CLK_MIN_PERIOD_NS = 8;
  localparam int USR_EN_PERIODS = 4;
  localparam int USR_EN_CYC = (USR_EN_PERIODS * CFG_CLK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_DIV = 4;
  localparam int AS_HALF = 4;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int TMR_W = 18;
  localparam int INIT_W = 14;
  localparam int WCNT_W = 16;
  localparam int RATIO_W = 3;
  localparam logic [7:0] AS_READ_CMD = 8'h0b;
  localparam logic [3:0] AS_CMD_BITS = 4'h8;
  localparam logic [1:0] AS_LAST_NIB = 2'h3;

  typedef enum logic [1:0] {
    SRC_OSC = 2'b00,
    SRC_CFG = 2'b01,
    SRC_USER = 2'b10
  } init_src_e;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_WAIT_LINE = 3'b001,
    ST_LOAD = 3'b010,
    ST_DRAIN = 3'b011,
    ST_USR_WAIT = 3'b100,
    ST_INIT = 3'b101,
    ST_USER = 3'b110
  } load_state_e;

  typedef struct packed {
    logic active_serial;
    logic wide;
    logic encrypt;
    logic compress;
    init_src_e init_src;
  } load_opts_s;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } word_s;

  function automatic logic [RATIO_W-1:0] ratio_of(input load_opts_s o);
    if (o.active_serial) begin
      ratio_of = 3'h1;
    end else if (o.wide) begin
      ratio_of = o.compress ? 3'h4 : (o.encrypt ? 3'h2 : 3'h1);
    end else begin
      ratio_of = o.compress ? 3'h2 : 3'h1;
    end
  endfunction
endpackage

/* src/pin_sync.sv */
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

/* src/cfg_loader.sv */
module cfg_loader #(
  parameter int STATUS_MIN_CYC = cfg_load_pkg::STATUS_MIN_CYC,
  parameter int INIT_CYCLES = cfg_load_pkg::INIT_CYCLES,
  parameter int WORDS_TO_LOAD = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic reconfig_request_n,
  input wire logic cfg_clock,
  input wire logic [cfg_load_pkg::WORD_W-1:0] cfg_data,
  input wire logic user_init_clock,
  input wire logic [cfg_load_pkg::NIB_W-1:0] serial_flash_io,
  input wire logic cfg_error_flag_n_i,
  output logic cfg_error_flag_n_o,
  output logic cfg_error_flag_n_oe,
  input wire cfg_load_pkg::load_opts_s load_opts,
  output logic load_complete,
  output logic user_mode,
  output cfg_load_pkg::word_s load_word,
  output logic flash_sclk,
  output logic serial_flash_cmd_out
);
  localparam int SYNC_W = 4 + cfg_load_pkg::NIB_W + cfg_load_pkg::WORD_W;
  localparam int TW = cfg_load_pkg::TMR_W;

  cfg_load_pkg::load_state_e state_q, state_d;
  cfg_load_pkg::load_opts_s opts_q;
  cfg_load_pkg::word_s word_q;
  logic [SYNC_W-1:0] sync_q;
  logic req_s, cclk_s, uclk_s, line_s;
  logic [cfg_load_pkg::NIB_W-1:0] io_s;
  logic [cfg_load_pkg::WORD_W-1:0] data_s;
  logic req_d_q, cclk_d_q, uclk_d_q;
  logic req_fall, cfg_rise, usr_rise;
  logic [TW-1:0] tmr_q;
  logic [cfg_load_pkg::RATIO_W-1:0] ratio_q, skip_q;
  logic [cfg_load_pkg::WCNT_W-1:0] word_cnt_q;
  logic [cfg_load_pkg::INIT_W-1:0] init_cnt_q;
  logic [1:0] osc_q, nib_q;
  logic osc_tick, init_tick;
  logic [2:0] div_q;
  logic sclk_q, cmd_out_q, as_run, as_fall, word_take;
  logic [7:0] cmd_q;
  logic [3:0] cmd_left_q;
  logic [11:0] as_cap_q;
  logic oe_q, done_q, user_q;

  pin_sync #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d({reconfig_request_n, cfg_clock, user_init_clock, cfg_error_flag_n_i, serial_flash_io, cfg_data}),
    .q(sync_q)
  );
  assign {req_s, cclk_s, uclk_s, line_s, io_s, data_s} = sync_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      // matches the synchroniser's reset level so no false request edge follows reset
      req_d_q <= 1'b0;
      cclk_d_q <= 1'b0;
      uclk_d_q <= 1'b0;
      osc_q <= 2'h0;
    end else if (clk_en) begin
      req_d_q <= req_s;
      cclk_d_q <= cclk_s;
      uclk_d_q <= uclk_s;
      osc_q <= osc_tick ? 2'h0 : 2'(osc_q + 1'b1);
    end
  end
  assign req_fall = req_d_q & ~req_s;
  assign cfg_rise = cclk_s & ~cclk_d_q;
  assign usr_rise = uclk_s & ~uclk_d_q;
  assign osc_tick = (osc_q == 2'(cfg_load_pkg::OSC_DIV - 1));

  always_comb begin
    case (opts_q.init_src)
      cfg_load_pkg::SRC_CFG: init_tick = cfg_rise;
      cfg_load_pkg::SRC_USER: init_tick = usr_rise;
      default: init_tick = osc_tick;
    endcase
  end

  // serial word: three held nibbles plus the one on the current falling edge
  assign word_take = (state_q == cfg_load_pkg::ST_LOAD) &&
    (opts_q.active_serial ? (as_fall && cmd_left_q == 4'h0 && nib_q == cfg_load_pkg::AS_LAST_NIB)
                          : (cfg_rise && skip_q == '0));

  always_comb begin
    state_d = state_q;
    case (state_q)
      cfg_load_pkg::ST_CLEAR: begin
        if (req_s && tmr_q >= TW'(STATUS_MIN_CYC - 1)) state_d = cfg_load_pkg::ST_WAIT_LINE;
      end
      cfg_load_pkg::ST_WAIT_LINE: begin
        // an outside party holding the line low delays the load
        if (line_s) state_d = cfg_load_pkg::ST_LOAD;
      end
      cfg_load_pkg::ST_LOAD: begin
        if (word_take && word_cnt_q == cfg_load_pkg::WCNT_W'(WORDS_TO_LOAD - 1)) state_d = cfg_load_pkg::ST_DRAIN;
      end
      cfg_load_pkg::ST_DRAIN: begin
        if (skip_q == '0) begin
          state_d = (opts_q.init_src == cfg_load_pkg::SRC_USER) ? cfg_load_pkg::ST_USR_WAIT : cfg_load_pkg::ST_INIT;
        end
      end
      cfg_load_pkg::ST_USR_WAIT: begin
        if (tmr_q == TW'(cfg_load_pkg::USR_EN_CYC - 1)) state_d = cfg_load_pkg::ST_INIT;
      end
      cfg_load_pkg::ST_INIT: begin
        if (init_tick && init_cnt_q == cfg_load_pkg::INIT_W'(INIT_CYCLES - 1)) state_d = cfg_load_pkg::ST_USER;
      end
      default: state_d = state_q;
    endcase
    if (req_fall) state_d = cfg_load_pkg::ST_CLEAR;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= cfg_load_pkg::ST_CLEAR;
      tmr_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (req_fall || state_d != state_q) tmr_q <= '0;
      else if (tmr_q != '1) tmr_q <= TW'(tmr_q + 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opts_q <= '0;
      ratio_q <= 3'h1;
    end else if (clk_en && state_q == cfg_load_pkg::ST_WAIT_LINE && state_d == cfg_load_pkg::ST_LOAD) begin
      opts_q <= load_opts;
      ratio_q <= cfg_load_pkg::ratio_of(load_opts);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      word_q <= '0;
      word_cnt_q <= '0;
      skip_q <= '0;
    end else if (clk_en) begin
      word_q.valid <= word_take;
      if (word_take) begin
        // parallel data is only stable long enough because the host holds it
        word_q.data <= opts_q.active_serial ? {as_cap_q, io_s} : data_s;
      end
      if (state_q != cfg_load_pkg::ST_LOAD && state_q != cfg_load_pkg::ST_DRAIN) begin
        word_cnt_q <= '0;
        skip_q <= '0;
      end else if (word_take) begin
        word_cnt_q <= word_cnt_q + 1'b1;
        skip_q <= ratio_q - 1'b1;
      end else if (cfg_rise && skip_q != '0 && !opts_q.active_serial) begin
        skip_q <= skip_q - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      init_cnt_q <= '0;
    end else if (clk_en) begin
      if (state_q != cfg_load_pkg::ST_INIT) init_cnt_q <= '0;
      else if (init_tick) init_cnt_q <= init_cnt_q + 1'b1;
    end
  end

  // flash clock from a divider; both launch and capture happen as it falls
  assign as_run = (state_q == cfg_load_pkg::ST_LOAD) && opts_q.active_serial;
  assign as_fall = as_run && sclk_q && (div_q == 3'(cfg_load_pkg::AS_HALF - 1));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q <= 3'h0;
      sclk_q <= 1'b0;
      cmd_q <= cfg_load_pkg::AS_READ_CMD;
      cmd_left_q <= cfg_load_pkg::AS_CMD_BITS;
      cmd_out_q <= 1'b0;
      as_cap_q <= '0;
      nib_q <= 2'h0;
    end else if (clk_en) begin
      if (!as_run) begin
        div_q <= 3'h0;
        sclk_q <= 1'b0;
        cmd_q <= cfg_load_pkg::AS_READ_CMD;
        cmd_left_q <= cfg_load_pkg::AS_CMD_BITS;
        nib_q <= 2'h0;
      end else begin
        if (div_q == 3'(cfg_load_pkg::AS_HALF - 1)) begin
          div_q <= 3'h0;
          sclk_q <= ~sclk_q;
        end else begin
          div_q <= div_q + 1'b1;
        end
        if (as_fall && cmd_left_q != 4'h0) begin
          cmd_out_q <= cmd_q[7];
          cmd_q <= {cmd_q[6:0], 1'b0};
          cmd_left_q <= cmd_left_q - 1'b1;
        end else if (as_fall) begin
          as_cap_q <= {as_cap_q[7:0], io_s};
          nib_q <= nib_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oe_q <= 1'b1;
      done_q <= 1'b0;
      user_q <= 1'b0;
    end else if (clk_en) begin
      oe_q <= (state_d == cfg_load_pkg::ST_CLEAR);
      done_q <= (state_d == cfg_load_pkg::ST_USR_WAIT) || (state_d == cfg_load_pkg::ST_INIT) ||
                (state_d == cfg_load_pkg::ST_USER);
      user_q <= (state_d == cfg_load_pkg::ST_USER);
    end
  end

  assign cfg_error_flag_n_o = 1'b0;
  assign cfg_error_flag_n_oe = oe_q;
  assign load_complete = done_q;
  assign user_mode = user_q;
  assign load_word = word_q;
  assign flash_sclk = sclk_q;
  assign serial_flash_cmd_out = cmd_out_q;

  // checking helpers
  logic [TW-1:0] hold_cnt_q, rel_cnt_q, cd_cnt_q;
  logic [cfg_load_pkg::INIT_W:0] tick_cnt_q;
  logic [cfg_load_pkg::RATIO_W-1:0] gap_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_cnt_q <= '0;
      rel_cnt_q <= '0;
      cd_cnt_q <= '0;
      tick_cnt_q <= '0;
      gap_q <= '0;
    end else if (clk_en) begin
      hold_cnt_q <= oe_q ? TW'(hold_cnt_q + 1'b1) : '0;
      rel_cnt_q <= (oe_q && req_s) ? TW'(rel_cnt_q + 1'b1) : '0;
      cd_cnt_q <= (done_q && !user_q) ? TW'(cd_cnt_q + 1'b1) : '0;
      if (state_q != cfg_load_pkg::ST_INIT && state_q != cfg_load_pkg::ST_USER) tick_cnt_q <= '0;
      else if (state_q == cfg_load_pkg::ST_INIT && init_tick) tick_cnt_q <= tick_cnt_q + 1'b1;
      if (state_q != cfg_load_pkg::ST_LOAD || word_take) gap_q <= '0;
      else if (cfg_rise && !opts_q.active_serial) gap_q <= gap_q + 1'b1;
    end
  end

  localparam int DONE_LIM = cfg_load_pkg::CF2CD_CYC;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_req_fall;
    $fell(reconfig_request_n);
  endsequence
  sequence s_done_up_user;
    $rose(done_q) && opts_q.init_src == cfg_load_pkg::SRC_USER;
  endsequence

  AST_DONE_LOW: assert property (s_req_fall |-> ##[1:DONE_LIM] !load_complete)
    else $error("load_complete not low in time");
  AST_FLAG_LOW: assert property (s_req_fall |-> ##[1:DONE_LIM] cfg_error_flag_n_oe)
    else $error("status not pulled low in time");
  AST_FLAG_MIN: assert property ($fell(oe_q) |-> hold_cnt_q >= TW'(STATUS_MIN_CYC))
    else $error("status low too short");
  AST_FLAG_RELEASE: assert property (oe_q |-> rel_cnt_q < TW'(cfg_load_pkg::STATUS_MAX_CYC))
    else $error("status held too long after request high");
  AST_RATIO: assert property (state_q == cfg_load_pkg::ST_LOAD && !opts_q.active_serial &&
    (opts_q.compress || (opts_q.wide && opts_q.encrypt)) |-> ratio_q > 3'h1)
    else $error("ratio not multi-cycle with features on");
  AST_RATIO_WIDE: assert property (state_q == cfg_load_pkg::ST_LOAD && opts_q.wide && opts_q.compress &&
    !opts_q.active_serial |-> ratio_q == 3'h4)
    else $error("wide compressed ratio wrong");
  AST_WORD_GAP: assert property (word_q.valid && !opts_q.active_serial && word_cnt_q > 16'h1 |->
    $past(gap_q) == ratio_q - 1'b1)
    else $error("word spacing differs from ratio");
  AST_INIT_COUNT: assert property ($rose(user_q) |-> tick_cnt_q >= (cfg_load_pkg::INIT_W + 1)'(INIT_CYCLES))
    else $error("user mode before full init count");
  AST_USR_DELAY: assert property (s_done_up_user |-> (state_q == cfg_load_pkg::ST_USR_WAIT)[*4])
    else $error("user clock used too early");
  AST_OSC_WINDOW: assert property ($rose(user_q) && opts_q.init_src == cfg_load_pkg::SRC_OSC |->
    cd_cnt_q >= TW'(cfg_load_pkg::UM_MIN_CYC) && cd_cnt_q <= TW'(cfg_load_pkg::UM_MAX_CYC))
    else $error("oscillator init outside window");
  AST_AS_LAUNCH: assert property ($changed(cmd_out_q) |-> $past(as_fall))
    else $error("command bit changed off falling edge");
  AST_AS_CAPTURE: assert property ($changed(as_cap_q) |-> $past(as_fall) && $past(cmd_left_q) == 4'h0)
    else $error("flash data captured off falling edge");
endmodule

/* bench/cfg_host.sv */
module cfg_host (
  input wire logic sys_clk,
  input wire logic status_n,
  output logic reconfig_request_n,
  output logic cfg_clock,
  output logic [cfg_load_pkg::WORD_W-1:0] cfg_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reconfig_request_n = 1'b1;
    cfg_clock = 1'b0;
    cfg_data = 16'h5a5a;
  end

  // request held low for 2 us, launched just after a sys_clk edge
  task automatic restart();
    @(posedge sys_clk);
    #1 reconfig_request_n = 1'b0;
    repeat (200) @(posedge sys_clk);
    #1 reconfig_request_n = 1'b1;
  endtask

  // one 125 ns link period, equal phases; the clock rests low between frames
  task automatic tick();
    #62.5 cfg_clock = 1'b1;
    #62.5 cfg_clock = 1'b0;
  endtask

  task automatic load(input int words, input int ratio, input logic [15:0] base);
    wait (status_n === 1'b1);
    #2000;
    for (int w = 0; w < words; w++) begin
      cfg_data = base + 16'(w);
      repeat (ratio) tick();
    end
    // hold time over: the bus no longer shows the last word
    cfg_data = ~cfg_data;
  endtask
endmodule

/* bench/config_load_sequencing_bench.sv */
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module config_load_sequencing_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STAT_CYC = 50;
  localparam int WORDS = 4;
  localparam int INIT = cfg_load_pkg::INIT_CYCLES;
  logic sys_clk = 1'b0, reset = 1'b1, user_init_clock = 1'b0, usr_run = 1'b0, ext_hold = 1'b0;
  logic chk_words = 1'b1;
  logic [3:0] flash_io = 4'h0;
  logic [15:0] exp_base = 16'h0000;
  cfg_load_pkg::load_opts_s opts = '0;
  cfg_load_pkg::word_s load_word;
  logic req_n, cfg_clock, oe, o_n, load_complete, user_mode, flash_sclk, cmd_out;
  logic [15:0] cfg_data;
  int bad_count = 0, check_count = 0, word_n = 0, cyc = 0;
  // open-drain status wire with pull-up
  wire logic status_n = (oe ? o_n : 1'b1) & ~ext_hold;
  wire logic [2:0] obs = {user_mode, load_complete, oe};

  always #5 sys_clk = ~sys_clk;
  always #20 user_init_clock = usr_run ? ~user_init_clock : 1'b0;
  always @(posedge flash_sclk) flash_io <= flash_io + 4'h1;

  cfg_host host (.sys_clk(sys_clk), .status_n(status_n), .reconfig_request_n(req_n),
    .cfg_clock(cfg_clock), .cfg_data(cfg_data));

  cfg_loader #(.STATUS_MIN_CYC(STAT_CYC), .WORDS_TO_LOAD(WORDS)) DUT (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .reconfig_request_n(req_n),
    .cfg_clock(cfg_clock), .cfg_data(cfg_data), .user_init_clock(user_init_clock),
    .serial_flash_io(flash_io), .cfg_error_flag_n_i(status_n), .cfg_error_flag_n_o(o_n),
    .cfg_error_flag_n_oe(oe), .load_opts(opts), .load_complete(load_complete),
    .user_mode(user_mode), .load_word(load_word), .flash_sclk(flash_sclk),
    .serial_flash_cmd_out(cmd_out));

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      complete_run();
    end
  end

  always @(posedge sys_clk) begin
    #1;
    if (chk_words && load_word.valid === 1'b1) begin
      `CHK("word", exp_base + 16'(word_n), load_word.data)
      word_n++;
    end
  end

  task automatic wait_bit(input int b, input logic v, input int lim, output int n);
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic do_load(input cfg_load_pkg::load_opts_s o, input int r, input logic hold);
    int n;
    @(posedge sys_clk);
    #1 opts = o;
    word_n = 0;
    exp_base = exp_base + 16'h1111;
    ext_hold = hold;
    fork
      host.restart();
      begin
        wait_bit(1, 1'b0, cfg_load_pkg::CF2CD_CYC, n);
        `CHK("lc_fall", 1'b1, n < cfg_load_pkg::CF2CD_CYC)
        `CHK("st_fall", 1'b1, oe)
      end
    join
    `CHK("st_held", 1'b1, oe)
    wait_bit(0, 1'b0, 8, n);
    `CHK("st_rel", 1'b1, n < 8)
    if (hold) begin
      repeat (100) @(posedge sys_clk);
      #1;
      `CHK("held_lc", 1'b0, load_complete)
      ext_hold = 1'b0;
    end
    host.load(WORDS, r, exp_base);
    wait_bit(1, 1'b1, 50, n);
    `CHK("lc_rise", 1'b1, load_complete)
    `CHK("words", WORDS, word_n)
  endtask

  // every width, encryption and compression combination, then the oscillator init window
  task automatic parallel_loads();
    int n;
    int r;
    cfg_load_pkg::load_opts_s o;
    for (int i = 0; i < 8; i++) begin
      r = i[0] ? (i[2] ? 4 : 2) : ((i[2] && i[1]) ? 2 : 1);
      o = '{1'b0, i[2], i[1], i[0], cfg_load_pkg::SRC_OSC};
      do_load(o, r, i == 3);
    end
    wait_bit(2, 1'b1, 44000, n);
    `CHK("osc_min", 1'b1, n >= cfg_load_pkg::UM_MIN_CYC)
    `CHK("osc_max", 1'b1, n <= cfg_load_pkg::UM_MAX_CYC)
    `CHK("osc_cnt", 1'b1, n >= INIT * cfg_load_pkg::OSC_DIV - 8)
  endtask

  task automatic user_clock_load();
    int n;
    usr_run = 1'b1;
    do_load('{1'b0, 1'b0, 1'b0, 1'b0, cfg_load_pkg::SRC_USER}, 1, 1'b0);
    wait_bit(2, 1'b1, 36000, n);
    `CHK("usr_min", 1'b1, n >= cfg_load_pkg::USR_EN_CYC + INIT * 4 - 8)
    `CHK("usr_mode", 1'b1, user_mode)
    usr_run = 1'b0;
  endtask

  // flash model steps its nibble on each rising flash clock: first data nibbles are 9, a, b, c
  task automatic serial_load();
    logic [7:0] cmd;
    chk_words = 1'b0;
    @(posedge sys_clk);
    #1 opts = '{1'b1, 1'b0, 1'b0, 1'b0, cfg_load_pkg::SRC_OSC};
    host.restart();
    for (int k = 7; k >= 0; k--) begin
      @(negedge flash_sclk);
      #1 cmd[k] = cmd_out;
    end
    `CHK("cmd", cfg_load_pkg::AS_READ_CMD, cmd)
    for (int t = 0; t < 64 && load_word.valid !== 1'b1; t++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK("as_valid", 1'b1, load_word.valid)
    `CHK("as_word", 16'h9abc, load_word.data)
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    parallel_loads();
    user_clock_load();
    serial_load();
    complete_run();
  end
endmodule
